// [hw/dcwd_top.sv]
/*
 * Drive command word decoder: APB slave holding the command word, the
 * profile holding register, a status input register and one coil, plus
 * the level decoding of the command word into drive commands.
 * Assumes one 100 MHz clock, synchronous active-high reset, and fault
 * inputs that arrive asynchronously from the drive core.
 */
// The implementer's own choices: the APB register port and the placing of the registers.
// Functional notes
// RULE1 - Bits 1:0 select preset reference one to four.
// RULE2 - Client keeps bit 2 at zero; it is stored but decodes nothing.
// RULE3 - Bit 3 low coasts the motor immediately.
// RULE4 - Bit 4 low requests quick stop on the quick-stop ramp.
// RULE5 - Bit 5 low holds the present output frequency.
// RULE6 - Bit 6 high permits start; low stops on normal ramp.
// RULE7 - Fault acknowledge only on a zero-to-one change of bit 7.
// RULE8 - Acknowledge accepted only when fault cause gone and prerequisites done.
// RULE9 - Bit 8 high runs at jog speed.
// RULE10 - Bit 9 selects ramp set two, else ramp set one.
// RULE11 - Bit 10 high makes new process data take effect.
// RULE12 - Bit 10 low keeps the data last taken while valid.
// RULE13 - Commands follow bit levels only, no sequencing machine.
// RULE14 - Bit 11 reserved; bits 15:12 go to user functions.
// RULE15 - Profile selectable by writing holding register one.
// RULE16 - Coil is one-bit RW, input register RO, holding registers RW.
// RULE17 - Every access answered well within five milliseconds.
// RULE18 - Each bus request is a separate independent transaction.
// RULE19 - Word latched on accepted write; outputs hold until next write.
`timescale 1ns/1ps
`include "dcwd_regs.svh"

module dcwd_top (
   input  wire logic               ref_clk,
   input  wire logic               rst,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [11:0]        paddr,
   input  wire logic [31:0]        pwdata,
   input  wire logic [3:0]         pstrb,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire dcwd_pkg::dcwd_fault_in_s fault_in,
   output dcwd_pkg::dcwd_cmd_s     cmd,
   output logic                    bus_control,
   output logic                    fault_ack,
   output logic      [15:0]        profile_sel,
   output logic                    coil_out
);

   logic [15:0]          word_q;
   logic [15:0]          word_d;
   logic [15:0]          active_q;
   logic [15:0]          active_d;
   logic [15:0]          profile_q;
   logic                 coil_q;
   logic                 ack_seen_q;
   logic [31:0]          prdata_q;
   logic                 pready_q;
   logic                 pslverr_q;
   logic                 fault_ack_q;
   dcwd_pkg::dcwd_cmd_s  cmd_q;
   dcwd_pkg::dcwd_fault_in_s fin_meta_q;
   dcwd_pkg::dcwd_fault_in_s fin_sync_q;
   logic                 bus_control_q;
   logic                 setup;
   logic                 access;
   logic                 wr_cmd;
   logic                 mapped;
   logic                 ro_write;
   logic                 ack_edge;

   // Answer is prepared in setup; writes land only at the completing edge
   assign setup    = psel && !penable;   // RULE18
   assign access   = psel && penable && pready_q;
   assign mapped   = (paddr == `DCWD_OFS_CMD_WORD) || (paddr == `DCWD_OFS_PROFILE) ||
                     (paddr == `DCWD_OFS_STATUS) || (paddr == `DCWD_OFS_COIL);
   assign ro_write = pwrite && (paddr == `DCWD_OFS_STATUS);   // RULE16
   assign wr_cmd   = access && pwrite && (paddr == `DCWD_OFS_CMD_WORD) && pstrb[0] && pstrb[1];

   // Partial writes to the command word are dropped without pslverr to avoid torn commands
   always_comb begin
      word_d = pwdata[15:0];
      if (!wr_cmd) begin
         word_d = word_q;
      end
   end

   // Data is taken only while the valid bit of the new word is set
   always_comb begin
      active_d = active_q;   // RULE12
      if (wr_cmd && word_d[`DCWD_BIT_DATA_VALID]) begin
         active_d = word_d;   // RULE11
      end
   end

   // Edge seen on taken data only; stale words cannot acknowledge
   assign ack_edge = wr_cmd && word_d[`DCWD_BIT_DATA_VALID] &&
                     word_d[`DCWD_BIT_FAULT_ACK] && !active_q[`DCWD_BIT_FAULT_ACK];   // RULE7

   // Fault inputs come from the drive core domain
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fin_meta_q <= '0;
         fin_sync_q <= '0;
      end else begin
         fin_meta_q <= fault_in;
         fin_sync_q <= fin_meta_q;
      end
   end

   // Bus answer stage
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h00000000;
      end else begin
         pready_q  <= setup;   // RULE17
         pslverr_q <= setup && (!mapped || ro_write);
         prdata_q  <= 32'h00000000;
         if (setup && !pwrite) begin
            case (paddr)
               `DCWD_OFS_CMD_WORD: prdata_q <= {16'h0000, word_q};
               `DCWD_OFS_PROFILE:  prdata_q <= {16'h0000, profile_q};
               `DCWD_OFS_STATUS: begin
                  prdata_q[`DCWD_ST_BUS_CONTROL] <= word_q[`DCWD_BIT_DATA_VALID];
                  prdata_q[`DCWD_ST_FAULT]       <= fin_sync_q.fault_active;
                  prdata_q[`DCWD_ST_ACK_SEEN]    <= ack_seen_q;
               end
               `DCWD_OFS_COIL:     prdata_q <= {31'h00000000, coil_q};
               default:            prdata_q <= 32'h00000000;
            endcase
         end
      end
   end

   // Command word storage
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         word_q        <= `DCWD_RST_CMD_WORD;
         active_q      <= `DCWD_RST_CMD_WORD;
         bus_control_q <= 1'b0;
      end else begin
         word_q   <= word_d;     // RULE19
         active_q <= active_d;
         if (wr_cmd) begin
            bus_control_q <= word_d[`DCWD_BIT_DATA_VALID];   // RULE11
         end
      end
   end

   // Level decode of the taken word; no sequence state
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cmd_q <= '0;
         cmd_q.coast      <= 1'b1;
         cmd_q.quick_stop <= 1'b1;
         cmd_q.hold       <= 1'b1;
      end else begin
         cmd_q.preset_sel <= active_d[`DCWD_BIT_PRESET_HI:`DCWD_BIT_PRESET_LO];   // RULE1 RULE13
         cmd_q.coast      <= !active_d[`DCWD_BIT_COAST_N];   // RULE3
         cmd_q.quick_stop <= !active_d[`DCWD_BIT_QSTOP_N];   // RULE4
         cmd_q.hold       <= !active_d[`DCWD_BIT_HOLD_N];    // RULE5
         cmd_q.run_enable <= active_d[`DCWD_BIT_START];      // RULE6
         cmd_q.jog        <= active_d[`DCWD_BIT_JOG];        // RULE9
         cmd_q.ramp2      <= active_d[`DCWD_BIT_RAMP2];      // RULE10
         cmd_q.user_bits  <= active_d[`DCWD_BIT_USER_HI:`DCWD_BIT_USER_LO];   // RULE14
      end
   end

   // Acknowledge pulse, gated by cleared cause and completed prerequisites
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fault_ack_q <= 1'b0;
         ack_seen_q  <= 1'b0;
      end else begin
         fault_ack_q <= ack_edge && fin_sync_q.cond_clear && fin_sync_q.prereq_done;   // RULE8
         if (ack_edge && fin_sync_q.cond_clear && fin_sync_q.prereq_done) begin
            ack_seen_q <= 1'b1;
         end else if (wr_cmd && !word_d[`DCWD_BIT_FAULT_ACK]) begin
            ack_seen_q <= 1'b0;
         end
      end
   end

   // Profile holding register and the coil
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         profile_q <= `DCWD_RST_PROFILE;
         coil_q    <= `DCWD_RST_COIL;
      end else if (access && pwrite) begin
         if (paddr == `DCWD_OFS_PROFILE) begin
            if (pstrb[0]) profile_q[7:0]  <= pwdata[7:0];   // RULE15
            if (pstrb[1]) profile_q[15:8] <= pwdata[15:8];
         end
         if (paddr == `DCWD_OFS_COIL && pstrb[0]) begin
            coil_q <= pwdata[0];   // RULE16
         end
      end
   end

   assign prdata      = prdata_q;
   assign pready      = pready_q;
   assign pslverr     = pslverr_q;
   assign cmd         = cmd_q;
   assign bus_control = bus_control_q;
   assign fault_ack   = fault_ack_q;
   assign profile_sel = profile_q;
   assign coil_out    = coil_q;

endmodule : dcwd_top

// [inc/dcwd_regs.svh]
/*
 * Register map, reset values, field positions and timing figures of the
 * drive command word decoder. Included by bare name wherever needed.
 */
`ifndef DCWD_REGS_SVH
`define DCWD_REGS_SVH

// Byte offsets on the APB bus
`define DCWD_OFS_CMD_WORD     12'h000
`define DCWD_OFS_PROFILE      12'h004
`define DCWD_OFS_STATUS       12'h008
`define DCWD_OFS_COIL         12'h00C

// Reset values; an all-zero word means coast, which is the safe state
`define DCWD_RST_CMD_WORD     16'h0000
`define DCWD_RST_PROFILE      16'h0000
`define DCWD_RST_COIL         1'h0

// Command word field positions
`define DCWD_BIT_PRESET_LO    0
`define DCWD_BIT_PRESET_HI    1
`define DCWD_BIT_RESERVED_A   2
`define DCWD_BIT_COAST_N      3
`define DCWD_BIT_QSTOP_N      4
`define DCWD_BIT_HOLD_N       5
`define DCWD_BIT_START        6
`define DCWD_BIT_FAULT_ACK    7
`define DCWD_BIT_JOG          8
`define DCWD_BIT_RAMP2        9
`define DCWD_BIT_DATA_VALID   10
`define DCWD_BIT_RESERVED_B   11
`define DCWD_BIT_USER_LO      12
`define DCWD_BIT_USER_HI      15

// Status field positions
`define DCWD_ST_BUS_CONTROL   0
`define DCWD_ST_FAULT         1
`define DCWD_ST_ACK_SEEN      2

// Response time limit per variable and the same figure in 100 MHz cycles
`define DCWD_CLK_MHZ          100
`define DCWD_RESP_MAX_MS      5
`define DCWD_RESP_MAX_CYC     (`DCWD_RESP_MAX_MS * 1000 * `DCWD_CLK_MHZ)

`endif

// [inc/dcwd_pkg.sv]
/*
 * Types of the drive command word decoder.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package dcwd_pkg;

   typedef struct packed {
      logic [1:0] preset_sel;
      logic       coast;
      logic       quick_stop;
      logic       hold;
      logic       run_enable;
      logic       jog;
      logic       ramp2;
      logic [3:0] user_bits;
   } dcwd_cmd_s;

   typedef struct packed {
      logic       fault_active;
      logic       cond_clear;
      logic       prereq_done;
   } dcwd_fault_in_s;

endpackage : dcwd_pkg

// [verification/dcwd_client.sv]
/* Client model: an APB master that issues single register transfers.
   Assumes the bench calls xfer and dcwd_top answers with pready. */
`timescale 1ns/1ps
module dcwd_client (
   input  wire logic        ref_clk,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [11:0] paddr,
   output logic      [31:0] pwdata,
   output logic      [3:0]  pstrb
);
   initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
   // Starts on a fresh edge, so a release never meets a new setup in one step
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge ref_clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= (a == 12'h000) ? (d & 32'hFFFF_FFFB) : d;
      pstrb   <= 4'hF;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      q = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
endmodule : dcwd_client

// [verification/dcwd_properties.sv]
/* Checker on dcwd_top ports: bus answers and command decoding.
   Assumes dcwd_pkg is compiled first; attached by the bind below. */
`timescale 1ns/1ps
module dcwd_properties (
   input wire logic                ref_clk,
   input wire logic                rst,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [11:0]         paddr,
   input wire logic [31:0]         pwdata,
   input wire logic [3:0]          pstrb,
   input wire logic                pready,
   input wire logic                pslverr,
   input wire dcwd_pkg::dcwd_cmd_s cmd,
   input wire logic                bus_control,
   input wire logic                fault_ack
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic        setup;
   logic        wr_cmd;
   logic [11:0] exp_cmd;
   assign setup   = psel && !penable;
   assign wr_cmd  = psel && penable && pready && pwrite && paddr == 12'h000 &&
                    pstrb[1:0] == 2'b11;
   assign exp_cmd = {pwdata[1:0], ~pwdata[3], ~pwdata[4], ~pwdata[5], pwdata[6],
                     pwdata[8], pwdata[9], pwdata[15:12]};
   a_ready_next: assert property (setup |=> pready)
      else $error("no answer after setup");
   a_err_unmapped: assert property (setup && paddr >= 12'h010 |=> pready && pslverr)
      else $error("unmapped access not refused");
   a_status_ro: assert property (setup && pwrite && paddr == 12'h008 |=> pslverr)
      else $error("status write not refused");
   a_decode_word: assert property (wr_cmd && pwdata[10] |=> cmd == $past(exp_cmd))
      else $error("command decode wrong");
   a_keep_invalid: assert property (wr_cmd && !pwdata[10] |=> $stable(cmd))
      else $error("invalid word changed commands");
   a_bus_ctl: assert property (wr_cmd |=> bus_control == $past(pwdata[10]))
      else $error("bus control flag wrong");
   a_cmd_hold: assert property (!wr_cmd |=> $stable(cmd))
      else $error("commands moved without write");
   a_ack_pulse: assert property (fault_ack |=> !fault_ack)
      else $error("acknowledge longer than one cycle");
   c_valid_wr: cover property (wr_cmd && pwdata[10]);
   c_ack: cover property (fault_ack);
   c_err: cover property (pslverr);
endmodule : dcwd_properties

bind dcwd_top dcwd_properties u_props (.ref_clk, .rst, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pstrb, .pready, .pslverr, .cmd, .bus_control, .fault_ack);

// [verification/tb_top.sv]
/* Self-checking bench for dcwd_top with the client model as bus master.
   Assumes zero-wait answers; fault inputs need a few cycles to sync. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin err_total++; \
   $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_top;
   logic ref_clk = 1'b0, rst = 1'b1, psel, penable, pwrite, pready, pslverr;
   logic bus_control, fault_ack, coil_out;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, w, q;
   logic [3:0]  pstrb;
   logic [15:0] profile_sel;
   logic [33:0] exp_q[$];
   logic [33:0] e;
   dcwd_pkg::dcwd_fault_in_s fault_in = '0;
   dcwd_pkg::dcwd_cmd_s      cmd;
   int err_total = 0, num_checks = 0, ack_cnt = 0, n;
   always #5 ref_clk = ~ref_clk;
   dcwd_client u_cli (.ref_clk(ref_clk), .pready(pready), .prdata(prdata), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
   dcwd_top u_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .fault_in(fault_in), .cmd(cmd),
      .bus_control(bus_control), .fault_ack(fault_ack), .profile_sel(profile_sel),
      .coil_out(coil_out));
   // Monitor takes the oldest note whenever an answer shows
   always @(posedge ref_clk) begin
      if (pready === 1'b1) begin
         e = exp_q.pop_front();
         `CHK("pslverr", e[32], pslverr)
         if (e[33]) `CHK("prdata", e[31:0], prdata)
      end
      if (fault_ack === 1'b1) ack_cnt++;
   end
   task automatic acc(logic wr, logic [11:0] a, logic [31:0] d, logic rd, logic er);
      exp_q.push_back({rd, er, d});
      u_cli.xfer(wr, a, d, q);
      @(negedge ref_clk);
   endtask : acc
   task automatic wrap_up;
      if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up
   initial begin
      #100us;
      err_total++;
      wrap_up();
   end
   initial begin
      void'($urandom(98));
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      `CHK("cmd", 12'h380, cmd)
      for (int a = 0; a < 16; a += 4) acc(0, a[11:0], 0, a != 8, 0);
      for (int i = 0; i < 8; i++) begin
         w = $urandom_range(16'hFFFF, 0) & 32'hFF7B | 32'h400 | i[1:0];
         acc(1, 0, w, 0, 0);
         `CHK("cmd", {w[1:0], ~w[3], ~w[4], ~w[5], w[6], w[8], w[9], w[15:12]}, cmd)
         `CHK("bus_control", 1'b1, bus_control)
         acc(0, 0, w, 1, 0);
      end
      acc(1, 0, ~w & 32'hFB7B, 0, 0);
      `CHK("cmd", {w[1:0], ~w[3], ~w[4], ~w[5], w[6], w[8], w[9], w[15:12]}, cmd)
      `CHK("bus_control", 1'b0, bus_control)
      fault_in <= 3'b011;
      repeat (3) @(posedge ref_clk);
      n = ack_cnt;
      acc(1, 0, 32'h478, 0, 0);
      acc(1, 0, 32'h4F8, 0, 0);
      acc(1, 0, 32'h4F8, 0, 0);
      repeat (2) @(posedge ref_clk);
      `CHK("ack", n + 1, ack_cnt)
      fault_in <= 3'b001;
      acc(1, 0, 32'h478, 0, 0);
      acc(1, 0, 32'h4F8, 0, 0);
      repeat (2) @(posedge ref_clk);
      `CHK("ack", n + 1, ack_cnt)
      w = $urandom_range(16'hFFFF, 0);
      acc(1, 4, w, 0, 0);
      `CHK("profile_sel", w[15:0], profile_sel)
      acc(0, 4, w, 1, 0);
      acc(1, 12, 1, 0, 0);
      `CHK("coil_out", 1'b1, coil_out)
      acc(0, 12, 1, 1, 0);
      acc(1, 8, 0, 0, 1);
      acc(0, 12'h010, 0, 1, 1);
      repeat (3) @(posedge ref_clk);
      `CHK("queue", 0, exp_q.size())
      wrap_up();
   end
endmodule : tb_top
